/* File: hw/ccout_chan.v */
/*
 One capture/compare channel: enable and polarity bits, preloaded only when
 it has a complementary output, output gating per run/idle off-state
 selection, idle deadtime, capture enable.
 Assumes synchronous inputs on aclk; compare reference and capture edges
 come from the surrounding timer.
*/
`timescale 1ns/10ps
`include "ccout_consts.vh"

module ccout_chan (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] ctl_pre,
    input wire has_comp,
    input wire preload_ctl,
    input wire commutation_event,
    input wire main_output_enable,
    input wire idle_off_state_select,
    input wire run_off_state_select,
    input wire main_idle_level,
    input wire comp_idle_level,
    input wire [`DT_W-1:0] dead_cycles,
    input wire compare_reference,
    input wire is_input,
    input wire filtered_input,
    output wire [3:0] ctl_act,
    output wire main_out,
    output wire main_oe_n,
    output wire comp_out,
    output wire comp_oe_n,
    output wire capture_strobe
);

    reg [3:0] act_q;            // Active enable/polarity copy
    reg [2:0] st_q;             // Output state
    reg [`DT_W-1:0] dt_q;       // Idle deadtime counter
    reg in_q;                   // Previous input level
    reg mo_q, mo_en_q, co_q, co_en_q, cap_q;
    reg mo_d, mo_en_d, co_d, co_en_d;
    wire en, pol, cen, cpol, rise, fall;

    assign en = act_q[`F_EN];
    assign pol = act_q[`F_POL];
    assign cen = act_q[`F_CEN] & has_comp;
    assign cpol = act_q[`F_CPOL] & has_comp;
    assign ctl_act = act_q;
    assign main_out = mo_q;
    assign main_oe_n = ~mo_en_q;
    assign comp_out = co_q;
    assign comp_oe_n = ~co_en_q;
    assign capture_strobe = cap_q;
    assign rise = filtered_input & ~in_q;
    assign fall = ~filtered_input & in_q;

    // ---------------------------------------------------------------
    // Preload of control bits
    // ---------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            act_q <= 4'h0;
        end else if (!has_comp || !preload_ctl || commutation_event) begin
            act_q <= ctl_pre;
        end
    end

    // ---------------------------------------------------------------
    // Run / forced / idle state and deadtime
    // ---------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= `ST_RUN;
            dt_q <= `DT_RST;
        end else begin
            case (st_q)
                `ST_RUN: begin
                    if (!main_output_enable && idle_off_state_select) begin
                        st_q <= `ST_FORCE;
                        dt_q <= dead_cycles;
                    end
                end
                `ST_FORCE: begin
                    if (main_output_enable || !idle_off_state_select) begin
                        st_q <= `ST_RUN;
                    end else if (dt_q == `RST_BYTE) begin
                        st_q <= `ST_IDLE;
                    end else begin
                        dt_q <= dt_q - 1'b1;
                    end
                end
                `ST_IDLE: begin
                    if (main_output_enable || !idle_off_state_select) begin
                        st_q <= `ST_RUN;
                    end
                end
                default: st_q <= `ST_RUN;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Output gating table
    // ---------------------------------------------------------------
    always @* begin
        mo_d = 1'b0;
        mo_en_d = 1'b0;
        co_d = 1'b0;
        co_en_d = 1'b0;
        if (is_input) begin
            // Input channel drives nothing
            mo_en_d = 1'b0;
        end else if (main_output_enable) begin
            if (en) begin
                mo_en_d = 1'b1;
                mo_d = compare_reference ^ pol;
            end else if (cen && run_off_state_select) begin
                mo_en_d = 1'b1;
                mo_d = pol;
            end
            if (cen) begin
                co_en_d = 1'b1;
                co_d = (en ? ~compare_reference : compare_reference) ^ cpol;
            end else if (en && run_off_state_select && has_comp) begin
                co_en_d = 1'b1;
                co_d = cpol;
            end
        end else if (idle_off_state_select) begin
            mo_en_d = 1'b1;
            co_en_d = has_comp;
            mo_d = st_q[2] ? main_idle_level : pol;
            co_d = st_q[2] ? comp_idle_level : cpol;
        end
    end

    // ---------------------------------------------------------------
    // Registered outputs and capture strobe
    // ---------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            mo_q <= 1'b0;
            mo_en_q <= 1'b0;
            co_q <= 1'b0;
            co_en_q <= 1'b0;
            cap_q <= 1'b0;
            in_q <= 1'b0;
        end else begin
            mo_q <= mo_d;
            mo_en_q <= mo_en_d;
            co_q <= co_d;
            co_en_q <= co_en_d;
            in_q <= filtered_input;
            cap_q <= is_input & en & (pol ? fall : rise);
        end
    end

endmodule

/* File: hw/ccout_ctrl.v */
/*
 Output control for four capture/compare channels, complementary outputs on
 channels 1 to 3 only, with an AXI4-Lite register slave and a capture
 register for channel 1 only.
 Assumes counter, compare references, filtered inputs and a commutation
 pulse arrive synchronous to aclk; pins are resolved by the port logic.
*/
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "ccout_consts.vh"

module ccout_ctrl (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [15:0] counter_value,
    input wire [3:0] compare_reference,
    input wire [3:0] chan_is_input,
    input wire [3:0] filtered_input,
    input wire commutation_event,
    output reg [3:0] chan_main_out,
    output reg [3:0] chan_main_oe_n,
    output reg [3:0] chan_comp_out,
    output reg [3:0] chan_comp_oe_n,
    output reg [15:0] capture_value_1
);

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    reg [7:0] ccen1_q;          // Channel 1/2 preload bits
    reg [7:0] ccen2_q;          // Channel 3/4 preload bits
    reg [31:0] ctrl_q;          // Main enable, off selects, idle levels
    reg [3:0] cap_seen_q;       // Sticky capture flags
    reg aw_q, w_q;              // Captured halves of a write
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg [31:0] rd_d;
    reg rd_ok_d;
    wire [15:0] act;            // Active copies, four bits per channel
    wire [3:0] mo, mo_en_n, co, co_en_n, cap;
    wire [3:0] ccen1_w, ccen2_w;
    wire wr_go;
    wire cap_clr;

    assign wr_go = aw_q && w_q && !s_axi_bvalid;
    assign cap_clr = wr_go && awaddr_q == `ADDR_STAT && wstrb_q[0];

    // ---------------------------------------------------------------
    // Channels
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : ch
            wire [3:0] pre;
            assign pre = (g == 0) ? ccen1_q[3:0] : (g == 1) ? ccen1_q[7:4] :
                         (g == 2) ? ccen2_q[3:0] : {2'b00, ccen2_q[5:4]};
            ccout_chan u_chan (
                .aclk(aclk),
                .aresetn(aresetn),
                .ctl_pre(pre),
                .has_comp(g != 3),
                .preload_ctl(ctrl_q[`CTRL_ENABLE_PRELOAD_CONTROL]),
                .commutation_event(commutation_event),
                .main_output_enable(ctrl_q[`CTRL_MOE]),
                .idle_off_state_select(ctrl_q[`CTRL_IDLE_OFF_STATE_SELECT]),
                .run_off_state_select(ctrl_q[`CTRL_RUN_OFF_STATE_SELECT]),
                .main_idle_level(ctrl_q[`CTRL_IDLE_LO + 2 * g]),
                .comp_idle_level(ctrl_q[`CTRL_IDLE_LO + 2 * g + 1]),
                .dead_cycles(ctrl_q[23:16]),
                .compare_reference(compare_reference[g]),
                .is_input(chan_is_input[g]),
                .filtered_input(filtered_input[g]),
                .ctl_act(act[4 * g + 3:4 * g]),
                .main_out(mo[g]),
                .main_oe_n(mo_en_n[g]),
                .comp_out(co[g]),
                .comp_oe_n(co_en_n[g]),
                .capture_strobe(cap[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // Pin-facing outputs, registered
    // ---------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            chan_main_out <= 4'h0;
            chan_main_oe_n <= 4'hf;
            chan_comp_out <= 4'h0;
            chan_comp_oe_n <= 4'hf;
            capture_value_1 <= 16'h0000;
            cap_seen_q <= 4'h0;
        end else begin
            chan_main_out <= mo;
            chan_main_oe_n <= mo_en_n;
            chan_comp_out <= co;
            chan_comp_oe_n <= co_en_n;
            if (cap[0]) begin
                capture_value_1 <= counter_value;
            end
            // Set wins over clear
            cap_seen_q <= (cap_clr ? cap_seen_q & ~wdata_q[3:0] : cap_seen_q) | cap;
        end
    end

    // ---------------------------------------------------------------
    // AXI write channel
    // ---------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= `RST_WORD;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            ccen1_q <= `RST_BYTE;
            ccen2_q <= `RST_BYTE;
            ctrl_q <= `RST_WORD;
        end else begin
            s_axi_awready <= !aw_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            // Commutation pulse bit self-clears
            ctrl_q[`CTRL_COM] <= 1'b0;
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                case (awaddr_q)
                    `ADDR_CCEN1: if (wstrb_q[0]) ccen1_q <= wdata_q[7:0];
                    `ADDR_CCEN2: if (wstrb_q[0]) ccen2_q <= wdata_q[7:0] & `CCEN2_MASK;
                    `ADDR_CTRL: begin
                        if (wstrb_q[0]) ctrl_q[7:0] <= wdata_q[7:0] & `CTRL_LO_MASK;
                        if (wstrb_q[1]) ctrl_q[15:8] <= wdata_q[15:8];
                        if (wstrb_q[2]) ctrl_q[23:16] <= wdata_q[23:16];
                    end
                    `ADDR_STAT: s_axi_bresp <= `RESP_OKAY;
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // AXI read channel
    // ---------------------------------------------------------------
    always @* begin
        rd_d = `RST_WORD;
        rd_ok_d = 1'b1;
        case (s_axi_araddr)
            `ADDR_CCEN1: rd_d = {24'h000000, ccen1_q};
            `ADDR_CCEN2: rd_d = {24'h000000, ccen2_q & `CCEN2_MASK};
            `ADDR_CTRL: rd_d = ctrl_q;
            `ADDR_CAPT: rd_d = {16'h0000, capture_value_1};
            `ADDR_STAT: rd_d = {act, 12'h000, cap_seen_q};
            default: rd_ok_d = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `RST_WORD;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_d;
                s_axi_rresp <= rd_ok_d ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* File: pkg/ccout_consts.vh */
/*
 Constants for the capture/compare output control block: register offsets,
 field positions, reset values and state codes.
 Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
*/
`ifndef CCOUT_CONSTS_VH
`define CCOUT_CONSTS_VH

// ---------------------------------------------------------------
// Register byte addresses (printed offsets are indices, times four)
// ---------------------------------------------------------------
`define IDX_CCEN1 8'h0c
`define IDX_CCEN2 8'h0d
`define ADDR_CCEN1 8'h30
`define ADDR_CCEN2 8'h34
`define ADDR_CTRL 8'h40
`define ADDR_CAPT 8'h44
`define ADDR_STAT 8'h48

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define F_EN 0
`define F_POL 1
`define F_CEN 2
`define F_CPOL 3
`define CTRL_MOE 0
`define CTRL_IDLE_OFF_STATE_SELECT 1
`define CTRL_RUN_OFF_STATE_SELECT 2
`define CTRL_ENABLE_PRELOAD_CONTROL 3
`define CTRL_COM 4
`define CTRL_IDLE_LO 8
`define CCEN2_MASK 8'h3f
`define CTRL_MASK 32'h0000ff0f
`define CTRL_LO_MASK 8'h0f

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_WORD 32'h00000000
`define DT_W 8
`define DT_RST 8'h08

// ---------------------------------------------------------------
// Per-channel output state (one-hot)
// ---------------------------------------------------------------
`define ST_RUN 3'b001
`define ST_FORCE 3'b010
`define ST_IDLE 3'b100

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

/* File: tb/ccout_ctrl_props.sv */
/*
 Checker for the capture/compare output control block: AXI handshakes,
 capture causes, undriven outputs. Bound to the top module, ports only.
*/
`timescale 1ns/10ps
`include "ccout_consts.vh"

module ccout_ctrl_props (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire [3:0] chan_is_input,
    input wire [3:0] filtered_input,
    input wire [3:0] chan_main_oe_n,
    input wire [3:0] chan_comp_oe_n,
    input wire [15:0] capture_value_1
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_quiet_a: assert property (
        $rose(aresetn) |-> (&chan_main_oe_n) && (&chan_comp_oe_n))
        else $error("outputs driven right after reset");
    ch4_no_comp_a: assert property (chan_comp_oe_n[3])
        else $error("channel 4 complementary output driven");
    input_quiet_a: assert property (
        chan_is_input[0] && $past(chan_is_input[0]) && $past(chan_is_input[0], 2)
        && $past(chan_is_input[0], 3) |-> chan_main_oe_n[0] && chan_comp_oe_n[0])
        else $error("input channel drives its outputs");
    cap_cause_a: assert property (
        capture_value_1 != $past(capture_value_1) |->
        ($past(filtered_input[0], 2) != $past(filtered_input[0], 3))
        || ($past(filtered_input[0], 3) != $past(filtered_input[0], 4))
        || ($past(filtered_input[0], 4) != $past(filtered_input[0], 5)))
        else $error("capture value changed without an input edge");
    aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("write address ready longer than one cycle");
    r_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not offered after address taken");
    b_legal_a: assert property (
        s_axi_bvalid |-> s_axi_bresp == `RESP_OKAY || s_axi_bresp == `RESP_SLVERR)
        else $error("illegal write response code");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response kept after acceptance");
    cover property (capture_value_1 != $past(capture_value_1));
    cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
    cover property (!chan_main_oe_n[0] && !chan_comp_oe_n[0]);
endmodule

bind ccout_ctrl ccout_ctrl_props props_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .chan_is_input(chan_is_input), .filtered_input(filtered_input),
    .chan_main_oe_n(chan_main_oe_n), .chan_comp_oe_n(chan_comp_oe_n),
    .capture_value_1(capture_value_1));

/* File: tb/power_stage_model.sv */
/*
 Pin-side model of the power stage: four pins with a pull resistor.
 Assumes the active-low drive enable from the block; undriven pins float to PULL.
*/
`timescale 1ns/10ps

module power_stage_model #(
    parameter logic PULL = 1'b1
) (
    input wire logic [3:0] drive,
    input wire logic [3:0] drive_oe_n,
    output wire logic [3:0] pin
);
    assign pin = (drive & ~drive_oe_n) | ({4{PULL}} & drive_oe_n);
endmodule

/* File: tb/tb.sv */
/*
 Self-checking bench for the output control block over AXI4-Lite.
 Assumes the pin model pulls undriven pins high.
*/
`timescale 1ns/10ps
`include "ccout_consts.vh"

module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, commutation_event;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rd;
    logic [3:0] compare_reference, chan_is_input, filtered_input;
    logic [15:0] counter_value;
    logic [1:0] resp;
    logic md, cd, mv, cv;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] main_out, main_oe_n, comp_out, comp_oe_n, main_pin, comp_pin;
    wire [15:0] capture_value_1;
    int err_count, checks_done;
    logic [7:0] regs[4] = '{`ADDR_CCEN1, `ADDR_CCEN2, `ADDR_CTRL, `ADDR_CAPT};
    logic [7:0] cap_en[4] = '{8'h01, 8'h03, 8'h03, 8'h02};
    logic [15:0] cap_cnt[4] = '{16'h1234, 16'h5555, 16'h6666, 16'h7777};
    logic [15:0] cap_exp[4] = '{16'h1234, 16'h5555, 16'h5555, 16'h5555};
    logic cap_fi[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    ccout_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .counter_value(counter_value),
        .compare_reference(compare_reference), .chan_is_input(chan_is_input),
        .filtered_input(filtered_input), .commutation_event(commutation_event),
        .chan_main_out(main_out), .chan_main_oe_n(main_oe_n), .chan_comp_out(comp_out),
        .chan_comp_oe_n(comp_oe_n), .capture_value_1(capture_value_1));
    power_stage_model main_stage_u (.drive(main_out), .drive_oe_n(main_oe_n), .pin(main_pin));
    power_stage_model comp_stage_u (.drive(comp_out), .drive_oe_n(comp_oe_n), .pin(comp_pin));

    // ----------------------------------------
    // Clock, watchdog and tasks
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        tally_and_finish();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rdreg(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
    // Expected as {main undriven, comp undriven, main pin, comp pin}
    task automatic pins(input int ch, input logic [3:0] exp, input string what);
        chk({main_oe_n[ch], comp_oe_n[ch], main_pin[ch], comp_pin[ch]}, exp, what);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, commutation_event} = 7'h00;
        {awaddr, araddr, wdata, counter_value} = 64'h0;
        {chan_is_input, filtered_input} = 8'h00;
        compare_reference = 4'hf;
        err_count = 0;
        checks_done = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        foreach (regs[i]) begin
            rdreg(regs[i]);
            chk(rd, 32'h0, "reset value");
        end
        pins(0, 4'hf, "reset undriven");
        rdreg(8'h3c);
        chk({resp, rd}, {`RESP_SLVERR, 32'h0}, "unmapped read");
        wr(8'h3c, 32'hff);
        chk(resp, `RESP_SLVERR, "unmapped write");
        $display("test registers done");
        // Every enable combination, both run off-state choices, channels 1 and 3
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 8; k++) begin
                md = k[1] | (k[2] & k[0]);
                cd = k[0] | (k[2] & k[1]);
                mv = md ? ~k[1] : 1'b1;
                cv = cd ? (k[0] ? ~k[1] : 1'b0) : 1'b1;
                wr(`ADDR_CTRL, {29'h0, k[2], 2'b01});
                wr(c ? `ADDR_CCEN2 : `ADDR_CCEN1, {28'h0, 1'b0, k[0], 1'b1, k[1]});
                repeat (12) @(posedge aclk);
                pins(2 * c, {~md, ~cd, mv, cv}, "output gating");
            end
        end
        wr(`ADDR_CCEN2, 32'hff);
        rdreg(`ADDR_CCEN2);
        chk(rd, 32'h3f, "reserved bits");
        repeat (12) @(posedge aclk);
        pins(3, 4'b0101, "channel 4 outputs");
        pins(2, 4'b0001, "channel 3 both on");
        $display("test output table done");
        wr(`ADDR_CCEN1, 32'h03);
        wr(`ADDR_CTRL, 32'h00140202);
        repeat (3) @(posedge aclk);
        pins(0, 4'b0010, "forced polarity");
        repeat (25) @(posedge aclk);
        pins(0, 4'b0001, "idle levels");
        wr(`ADDR_CTRL, 32'h0);
        repeat (4) @(posedge aclk);
        pins(0, 4'b1111, "outputs off");
        $display("test idle done");
        wr(`ADDR_CTRL, 32'h09);
        wr(`ADDR_CCEN1, 32'h0f);
        repeat (12) @(posedge aclk);
        rdreg(`ADDR_STAT);
        chk(rd[19:16], 4'h3, "active bits held");
        pins(0, 4'b0101, "before commutation");
        commutation_event <= 1'b1;
        @(posedge aclk);
        commutation_event <= 1'b0;
        repeat (12) @(posedge aclk);
        rdreg(`ADDR_STAT);
        chk(rd[19:16], 4'hf, "active bits loaded");
        pins(0, 4'b0001, "after commutation");
        $display("test preload done");
        // outputs off, channel 1 as input: capture per edge polarity and enable
        wr(`ADDR_CTRL, 32'h0);
        chan_is_input <= 4'h1;
        for (int s = 0; s < 4; s++) begin
            wr(`ADDR_CCEN1, {24'h0, cap_en[s]});
            counter_value <= cap_cnt[s];
            repeat (2) @(posedge aclk);
            filtered_input <= {3'b000, cap_fi[s]};
            repeat (6) @(posedge aclk);
            chk(capture_value_1, cap_exp[s], "capture value");
        end
        rdreg(`ADDR_CAPT);
        chk(rd, 32'h5555, "capture register");
        rdreg(`ADDR_STAT);
        chk(rd[3:0], 4'h1, "capture flag set");
        wr(`ADDR_STAT, 32'h1);
        rdreg(`ADDR_STAT);
        chk(rd[3:0], 4'h0, "capture flag cleared");
        $display("test capture done");
        tally_and_finish();
    end
endmodule
